// ==== rtl/crd_addr_encoder.sv ====
// Purpose: Encode address selector position into the display select code
// Assumes: Code is carried active low on the select lines
// Notes: Purely combinational
`timescale 1ns/1ps
`default_nettype none
`include "crd_params.svh"

module crd_addr_encoder (
    input wire crd_pkg::crd_apos_e pos_i,
    input wire logic maint_i,
    output logic [`CRD_ASEL_W-1:0] code_n_o,
    output logic valid_o
);
    import crd_pkg::*;

    always_comb begin
        valid_o = 1'b1;
        unique case (pos_i)
            CRD_AP_STORAGE: code_n_o = `CRD_ASEL_STORAGE;
            CRD_AP_MICRO: code_n_o = `CRD_ASEL_MICRO;
            CRD_AP_CONSOLE: code_n_o = `CRD_ASEL_CONSOLE;
            CRD_AP_ERROR: code_n_o = `CRD_ASEL_ERROR;
        endcase
        if (!maint_i &&
            (pos_i == CRD_AP_MICRO || pos_i == CRD_AP_ERROR)) begin
            valid_o = 1'b0;
        end
    end
endmodule // crd_addr_encoder

`default_nettype wire

// ==== rtl/crd_data_encoder.sv ====
// Purpose: Encode data selector position into the display select code
// Assumes: Position qualified here by the maintenance input
// Notes: Purely combinational
`timescale 1ns/1ps
`default_nettype none
`include "crd_params.svh"

module crd_data_encoder (
    input wire crd_pkg::crd_dpos_e pos_i,
    input wire logic maint_i,
    output logic [`CRD_DSEL_W-1:0] code_o,
    output logic arith_sel_o,
    output logic valid_o
);
    import crd_pkg::*;

    // ======================================================
    // Maintenance gating
    function automatic logic maint_only(input crd_dpos_e p);
        maint_only = (p != CRD_DP_BUSY) && (p != CRD_DP_CONSOLE);
    endfunction

    always_comb begin
        arith_sel_o = 1'b0;
        valid_o = 1'b1;
        code_o = `CRD_DSEL_NONE;
        if (maint_only(pos_i) && !maint_i) begin
            valid_o = 1'b0;
        end else begin
            unique case (pos_i)
                CRD_DP_BUSY: code_o = `CRD_DSEL_BUSY;
                CRD_DP_TICK: code_o = `CRD_DSEL_TICK;
                CRD_DP_FETCH1: code_o = `CRD_DSEL_FETCH1;
                CRD_DP_FETCH2: code_o = `CRD_DSEL_FETCH2;
                CRD_DP_SCAN: code_o = `CRD_DSEL_SCAN;
                CRD_DP_CONSOLE: code_o = `CRD_DSEL_CONSOLE;
                CRD_DP_GRP2CNT: code_o = `CRD_DSEL_GRP2CNT;
                CRD_DP_LATCH, CRD_DP_OPA, CRD_DP_OPB, CRD_DP_SUM: begin
                    code_o = `CRD_DSEL_ARITH;
                    arith_sel_o = 1'b1;
                end
                default: valid_o = 1'b0;
            endcase
        end
    end
endmodule // crd_data_encoder

`default_nettype wire

// ==== rtl/crd_display_select.sv ====
// Purpose: Console register display select path with AHB-Lite access
// Assumes: Selector positions come from registers written over the bus
// Notes: Display outputs are registered, one cycle behind the sources
//
// Function
// - Data selector offers busy, tick, fetch, scan, console, counter, arith.
// - Address selector offers storage, micro, console and error addresses.
// - Group-two positions pass an eight-input encoder to a three-bit code.
// - One shared signal marks any arithmetic choice and comes from the encoder.
// - Busy 7, scan 4, fetch 3 and 5, tick 6, counter 1, console 3, arith 0.
// - Data multiplexer takes sixteen lines per source plus the fan-out.
// - Arithmetic contents reach the display only in a null condition.
// - The arithmetic gate is the null read signal and the null state flag.
// - During scan or read a second multiplexer shows store or jump table.
// - For console display, outside scan or read, the second multiplexer passes the first.
// - Address positions give a two-bit active-low code to a 16-line mux.
// - Address codes: storage 01, console 11, error 00, micro upper bit 1.
// - The selected address value drives the address display lines.
// - Positions other than busy, console, storage need maintenance mode.
// - Outside maintenance mode those positions select nothing.
`timescale 1ns/1ps
`default_nettype none
`include "crd_params.svh"

module crd_display_select (
    input wire logic clk_i,
    input wire logic rst_i,
    // AHB-Lite slave
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    output logic [31:0] hrdata_o,
    output logic hreadyout_o,
    output logic hresp_o,
    // Panel mode and scan control
    input wire logic maint_mode_i,
    input wire logic scan_read_active_i,
    input wire logic table_source_select_i,
    // Arbitration network
    input wire logic null_read_signal_i,
    input wire logic null_state_flag_i,
    // Group-two registers
    input wire crd_pkg::crd_word_t busy_active_i,
    input wire crd_pkg::crd_word_t tick_counter_i,
    input wire crd_pkg::crd_word_t fetch1_i,
    input wire crd_pkg::crd_word_t fetch2_i,
    input wire crd_pkg::crd_word_t scan_reg_i,
    input wire crd_pkg::crd_word_t console_data_i,
    input wire crd_pkg::crd_word_t group_two_counter_i,
    // Arithmetic unit
    input wire crd_pkg::crd_word_t data_latch_i,
    input wire crd_pkg::crd_word_t operand_a_i,
    input wire crd_pkg::crd_word_t operand_b_i,
    // Second multiplexer sources
    input wire crd_pkg::crd_word_t control_store_i,
    input wire crd_pkg::crd_word_t jump_table_i,
    // Address registers
    input wire crd_pkg::crd_word_t storage_addr_i,
    input wire crd_pkg::crd_word_t micro_addr_i,
    input wire crd_pkg::crd_word_t console_addr_i,
    input wire crd_pkg::crd_word_t error_capture_address_i,
    // Panel indicators
    output logic [`CRD_DW-1:0] data_display_o,
    output logic [`CRD_DW-1:0] address_display_lines_o,
    output logic [`CRD_DSEL_W-1:0] data_display_select_code_o,
    output logic [`CRD_ASEL_W-1:0] address_display_select_code_n_o,
    output logic arith_quantity_selected_o,
    output logic arith_display_gate_o
);
    import crd_pkg::*;

    // ======================================================
    // Bus slave state
    logic [`CRD_DPOS_W-1:0] dpos_reg;
    logic [`CRD_APOS_W-1:0] apos_reg;
    logic wr_pend_reg;
    logic rd_pend_reg;
    logic [2:0] idx_reg;
    logic [31:0] rdata_reg;
    crd_word_t data_disp_reg;
    crd_word_t addr_disp_reg;
    crd_word_t arith_fanout;
    crd_word_t first_mux;
    crd_word_t second_mux;
    crd_word_t addr_mux;
    logic [`CRD_DSEL_W-1:0] dsel_code;
    logic [`CRD_ASEL_W-1:0] asel_code_n;
    logic arith_sel;
    logic dsel_valid;
    logic asel_valid;
    logic gate;
    logic addr_phase;
    crd_dpos_e dpos;
    crd_apos_e apos;

    // Word index from a byte address
    function automatic logic [2:0] word_idx(input logic [31:0] a);
        word_idx = a[`CRD_ADDR_MSB:`CRD_ADDR_LSB];
    endfunction

    assign addr_phase = hsel_i && htrans_i[1] && hready_i;
    assign hreadyout_o = 1'b1;
    assign hresp_o = 1'b0;
    assign hrdata_o = rdata_reg;

    // Unknown position codes fall back to off
    assign dpos = (dpos_reg > 4'(CRD_DP_SUM)) ? CRD_DP_OFF
                                              : crd_dpos_e'(dpos_reg);
    assign apos = crd_apos_e'(apos_reg);

    // ======================================================
    // Address phase capture
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            wr_pend_reg <= 1'b0;
            rd_pend_reg <= 1'b0;
            idx_reg <= 3'h0;
        end else begin
            wr_pend_reg <= addr_phase && hwrite_i;
            rd_pend_reg <= addr_phase && !hwrite_i;
            if (addr_phase) begin
                idx_reg <= word_idx(haddr_i);
            end
        end
    end

    // ======================================================
    // Selector position registers
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            dpos_reg <= `CRD_DPOS_RST;
            apos_reg <= `CRD_APOS_RST;
        end else if (wr_pend_reg) begin
            if (idx_reg == word_idx(`CRD_OFF_DSEL)) begin
                dpos_reg <= hwdata_i[`CRD_DPOS_W-1:0];
            end
            if (idx_reg == word_idx(`CRD_OFF_ASEL)) begin
                apos_reg <= hwdata_i[`CRD_APOS_W-1:0];
            end
        end
    end

    // ======================================================
    // Read data, sampled in the address phase
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            rdata_reg <= `CRD_ZERO32;
        end else if (addr_phase && !hwrite_i) begin
            unique case (word_idx(haddr_i))
                word_idx(`CRD_OFF_DSEL):
                    rdata_reg <= {28'h0, dpos_reg};
                word_idx(`CRD_OFF_ASEL):
                    rdata_reg <= {30'h0, apos_reg};
                word_idx(`CRD_OFF_STAT):
                    rdata_reg <= {22'h0, gate, arith_sel, asel_valid,
                                  dsel_valid, asel_code_n, 1'b0,
                                  dsel_code};
                word_idx(`CRD_OFF_DATA):
                    rdata_reg <= {16'h0, data_disp_reg};
                word_idx(`CRD_OFF_ADDR):
                    rdata_reg <= {16'h0, addr_disp_reg};
                default: rdata_reg <= `CRD_ZERO32;
            endcase
        end
    end

    // ======================================================
    // Encoders
    crd_data_encoder u_denc (
        .pos_i(dpos),
        .maint_i(maint_mode_i),
        .code_o(dsel_code),
        .arith_sel_o(arith_sel),
        .valid_o(dsel_valid)
    );

    crd_addr_encoder u_aenc (
        .pos_i(apos),
        .maint_i(maint_mode_i),
        .code_n_o(asel_code_n),
        .valid_o(asel_valid)
    );

    // ======================================================
    // Arithmetic fan-out, gated by the null condition
    assign gate = null_read_signal_i && null_state_flag_i;

    always_comb begin
        arith_fanout = `CRD_ZERO16;
        if (gate && arith_sel) begin
            unique case (dpos)
                CRD_DP_LATCH: arith_fanout = data_latch_i;
                CRD_DP_OPA: arith_fanout = operand_a_i;
                CRD_DP_OPB: arith_fanout = operand_b_i;
                CRD_DP_SUM: arith_fanout = operand_a_i + operand_b_i;
                default: arith_fanout = `CRD_ZERO16;
            endcase
        end
    end

    // ======================================================
    // Data multiplexers
    always_comb begin
        first_mux = `CRD_ZERO16;
        if (dsel_valid) begin
            unique case (dsel_code)
                `CRD_DSEL_BUSY: first_mux = busy_active_i;
                `CRD_DSEL_TICK: first_mux = tick_counter_i;
                `CRD_DSEL_FETCH2: first_mux = fetch2_i;
                `CRD_DSEL_SCAN: first_mux = scan_reg_i;
                `CRD_DSEL_GRP2CNT: first_mux = group_two_counter_i;
                `CRD_DSEL_ARITH: first_mux = arith_fanout;
                // Fetch one and console share a code
                `CRD_DSEL_FETCH1:
                    first_mux = (dpos == CRD_DP_CONSOLE) ? console_data_i
                                                         : fetch1_i;
                default: first_mux = `CRD_ZERO16;
            endcase
        end
    end

    always_comb begin
        if (scan_read_active_i) begin
            second_mux = table_source_select_i ? control_store_i
                                               : jump_table_i;
        end else begin
            second_mux = first_mux;
        end
    end

    // ======================================================
    // Address multiplexer
    always_comb begin
        addr_mux = `CRD_ZERO16;
        if (asel_valid) begin
            unique case (asel_code_n)
                `CRD_ASEL_STORAGE: addr_mux = storage_addr_i;
                `CRD_ASEL_MICRO: addr_mux = micro_addr_i;
                `CRD_ASEL_CONSOLE: addr_mux = console_addr_i;
                `CRD_ASEL_ERROR: addr_mux = error_capture_address_i;
            endcase
        end
    end

    // ======================================================
    // Indicator registers
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            data_disp_reg <= `CRD_ZERO16;
            addr_disp_reg <= `CRD_ZERO16;
        end else begin
            data_disp_reg <= second_mux;
            addr_disp_reg <= addr_mux;
        end
    end

    assign data_display_o = data_disp_reg;
    assign address_display_lines_o = addr_disp_reg;
    assign data_display_select_code_o = dsel_code;
    assign address_display_select_code_n_o = asel_code_n;
    assign arith_quantity_selected_o = arith_sel;
    assign arith_display_gate_o = gate && arith_sel;

    // Only the low word bits decode; upper address bits alias
    logic unused_ok;
    assign unused_ok = ^{hsize_i, htrans_i[0], rd_pend_reg};
endmodule // crd_display_select

`default_nettype wire

// ==== rtl/crd_params.svh ====
// Purpose: Constants for the console register display select block
// Assumes: Included by bare name from the package and design files
// Notes: Codes are those driven on the select lines
`ifndef CRD_PARAMS_SVH
`define CRD_PARAMS_SVH

// ==========================================================
// Widths
`define CRD_DW 16
`define CRD_DSEL_W 3
`define CRD_ASEL_W 2

// ==========================================================
// Data display select codes
`define CRD_DSEL_BUSY 3'h7
`define CRD_DSEL_SCAN 3'h4
`define CRD_DSEL_FETCH1 3'h3
`define CRD_DSEL_FETCH2 3'h5
`define CRD_DSEL_TICK 3'h6
`define CRD_DSEL_GRP2CNT 3'h1
`define CRD_DSEL_CONSOLE 3'h3
`define CRD_DSEL_ARITH 3'h0
`define CRD_DSEL_NONE 3'h2

// ==========================================================
// Address display select codes, active low on the lines
`define CRD_ASEL_STORAGE 2'h1
`define CRD_ASEL_MICRO 2'h2
`define CRD_ASEL_CONSOLE 2'h3
`define CRD_ASEL_ERROR 2'h0

// ==========================================================
// Register map, word offsets in bytes
`define CRD_OFF_DSEL 32'h0000_0000
`define CRD_OFF_ASEL 32'h0000_0004
`define CRD_OFF_STAT 32'h0000_0008
`define CRD_OFF_DATA 32'h0000_000c
`define CRD_OFF_ADDR 32'h0000_0010
`define CRD_ADDR_LSB 2
`define CRD_ADDR_MSB 4

// ==========================================================
// Selector position field widths and reset values
`define CRD_DPOS_W 4
`define CRD_APOS_W 2
`define CRD_DPOS_RST 4'h0
`define CRD_APOS_RST 2'h0
`define CRD_ZERO16 16'h0000
`define CRD_ZERO32 32'h0000_0000

`endif

// ==== rtl/crd_pkg.sv ====
// Purpose: Types for the console register display select block
// Assumes: crd_params.svh holds the numeric constants
// Notes: Position codes are local encodings of the selector knobs
`default_nettype none
`include "crd_params.svh"

package crd_pkg;
    // ======================================================
    // Data selector positions
    typedef enum logic [3:0] {
        CRD_DP_OFF = 4'h0,
        CRD_DP_BUSY = 4'h1,
        CRD_DP_TICK = 4'h2,
        CRD_DP_FETCH1 = 4'h3,
        CRD_DP_FETCH2 = 4'h4,
        CRD_DP_SCAN = 4'h5,
        CRD_DP_CONSOLE = 4'h6,
        CRD_DP_GRP2CNT = 4'h7,
        CRD_DP_LATCH = 4'h8,
        CRD_DP_OPA = 4'h9,
        CRD_DP_OPB = 4'ha,
        CRD_DP_SUM = 4'hb
    } crd_dpos_e;

    // ======================================================
    // Address selector positions
    typedef enum logic [1:0] {
        CRD_AP_STORAGE = 2'h0,
        CRD_AP_MICRO = 2'h1,
        CRD_AP_CONSOLE = 2'h2,
        CRD_AP_ERROR = 2'h3
    } crd_apos_e;

    typedef logic [`CRD_DW-1:0] crd_word_t;
endpackage

`default_nettype wire

// ==== sim/crd_display_select_asserts.sv ====
// Purpose: Port-level checks of the display select path
// Assumes: Display outputs lag their sources by one edge
// Notes: Attached by bind at the foot of this file
`timescale 1ns/1ps
`default_nettype none
`include "crd_params.svh"

// ==========================================================
// Checker
module crd_display_select_asserts (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic hreadyout_o,
    input wire logic hresp_o,
    input wire logic maint_mode_i,
    input wire logic scan_read_active_i,
    input wire logic table_source_select_i,
    input wire logic null_read_signal_i,
    input wire logic null_state_flag_i,
    input wire crd_pkg::crd_word_t control_store_i,
    input wire crd_pkg::crd_word_t jump_table_i,
    input wire crd_pkg::crd_word_t storage_addr_i,
    input wire crd_pkg::crd_word_t console_addr_i,
    input wire logic [`CRD_DW-1:0] data_display_o,
    input wire logic [`CRD_DW-1:0] address_display_lines_o,
    input wire logic [`CRD_DSEL_W-1:0] data_display_select_code_o,
    input wire logic [`CRD_ASEL_W-1:0] address_display_select_code_n_o,
    input wire logic arith_quantity_selected_o,
    input wire logic arith_display_gate_o
);
    import crd_pkg::*;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    bus_okay_a: assert property (hreadyout_o && !hresp_o)
        else $error("bus not ready or not okay");
    gate_and_a: assert property (arith_display_gate_o ==
        (null_read_signal_i && null_state_flag_i && arith_quantity_selected_o))
        else $error("arith gate mismatch");
    arith_code_a: assert property (arith_quantity_selected_o |->
        data_display_select_code_o == `CRD_DSEL_ARITH)
        else $error("arith code wrong");
    maint_arith_a: assert property (!maint_mode_i |->
        !arith_quantity_selected_o)
        else $error("arith chosen outside maintenance");
    maint_code_a: assert property (!maint_mode_i |->
        data_display_select_code_o inside {`CRD_DSEL_BUSY,
        `CRD_DSEL_CONSOLE, `CRD_DSEL_NONE})
        else $error("maintenance code outside maintenance");
    scan_store_a: assert property (scan_read_active_i &&
        table_source_select_i |=> data_display_o == $past(control_store_i))
        else $error("control store not shown");
    scan_table_a: assert property (scan_read_active_i &&
        !table_source_select_i |=> data_display_o == $past(jump_table_i))
        else $error("jump table not shown");
    arith_zero_a: assert property (arith_quantity_selected_o &&
        !arith_display_gate_o && !scan_read_active_i
        |=> data_display_o == 16'h0000)
        else $error("ungated arith value shown");
    addr_store_a: assert property (address_display_select_code_n_o ==
        `CRD_ASEL_STORAGE |=> address_display_lines_o == $past(storage_addr_i))
        else $error("storage address not shown");
    addr_cons_a: assert property (address_display_select_code_n_o ==
        `CRD_ASEL_CONSOLE |=> address_display_lines_o == $past(console_addr_i))
        else $error("console address not shown");

    cover property (arith_display_gate_o);
    cover property (scan_read_active_i && table_source_select_i);
    cover property (!maint_mode_i &&
        data_display_select_code_o == `CRD_DSEL_BUSY);
endmodule // crd_display_select_asserts

bind crd_display_select crd_display_select_asserts u_chk (.clk_i, .rst_i,
    .hreadyout_o, .hresp_o, .maint_mode_i, .scan_read_active_i,
    .table_source_select_i, .null_read_signal_i, .null_state_flag_i,
    .control_store_i, .jump_table_i, .storage_addr_i, .console_addr_i,
    .data_display_o, .address_display_lines_o, .data_display_select_code_o,
    .address_display_select_code_n_o, .arith_quantity_selected_o,
    .arith_display_gate_o);
`default_nettype wire

// ==== sim/crd_display_select_bench.sv ====
// Purpose: Self-checking bench for the display select path
// Assumes: Zero wait-state slave, positions set over the bus
// Notes: Sources come from the fixed-word model
`timescale 1ns/1ps
`default_nettype none
`include "crd_params.svh"

// ==========================================================
// Bench
module crd_display_select_bench;
    import crd_pkg::*;
    logic clk, rst, hsel, hwrite, maint, srd, ts, nr, ns;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] haddr, hwdata, hrdata, rd, e;
    logic hready, hresp;
    logic [15:0] dd, ad;
    logic [2:0] dsel;
    logic [1:0] asel;
    logic aqs, agate;
    crd_word_t w [16];
    logic [1:0] ac [4];
    int fail_count, n_checks;

    crd_src_model u_src (.w_o(w));
    crd_display_select u_dut (.clk_i(clk), .rst_i(rst), .hsel_i(hsel),
        .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
        .hsize_i(hsize), .hwdata_i(hwdata), .hready_i(hready),
        .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp),
        .maint_mode_i(maint), .scan_read_active_i(srd),
        .table_source_select_i(ts), .null_read_signal_i(nr),
        .null_state_flag_i(ns), .busy_active_i(w[0]),
        .tick_counter_i(w[1]), .fetch1_i(w[2]), .fetch2_i(w[3]),
        .scan_reg_i(w[4]), .console_data_i(w[5]),
        .group_two_counter_i(w[6]), .data_latch_i(w[7]),
        .operand_a_i(w[8]), .operand_b_i(w[9]), .control_store_i(w[10]),
        .jump_table_i(w[11]), .storage_addr_i(w[12]), .micro_addr_i(w[13]),
        .console_addr_i(w[14]), .error_capture_address_i(w[15]),
        .data_display_o(dd), .address_display_lines_o(ad),
        .data_display_select_code_o(dsel),
        .address_display_select_code_n_o(asel),
        .arith_quantity_selected_o(aqs), .arith_display_gate_o(agate));

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // ==========================================================
    // Tasks and expectations
    task automatic stop_test();
        if (fail_count == 0 && n_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Address phase held until ready, then data phase until ready
    task automatic bus(input logic [31:0] a, input logic wr,
                       input logic [31:0] d, output logic [31:0] q);
        @(posedge clk);
        haddr <= a;
        hwrite <= wr;
        htrans <= 2'h2;
        do @(posedge clk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hready !== 1'b1);
        q = hrdata;
    endtask

    function automatic logic [2:0] exp_c(int p, bit m);
        if (p == 0 || p > 11 || (!m && p != 1 && p != 6))
            return `CRD_DSEL_NONE;
        case (p)
            1: return `CRD_DSEL_BUSY;
            2: return `CRD_DSEL_TICK;
            3: return `CRD_DSEL_FETCH1;
            4: return `CRD_DSEL_FETCH2;
            5: return `CRD_DSEL_SCAN;
            6: return `CRD_DSEL_CONSOLE;
            7: return `CRD_DSEL_GRP2CNT;
            default: return `CRD_DSEL_ARITH;
        endcase
    endfunction

    function automatic logic [31:0] exp_d(int p, bit m, bit g);
        if (exp_c(p, m) == `CRD_DSEL_NONE || (p >= 8 && !g)) return 32'h0;
        if (p == 11) return {16'h0, w[8] + w[9]};
        return {16'h0, w[p - 1]};
    endfunction

    function automatic logic [31:0] exp_s(int p, bit m, bit g);
        logic [2:0] c;
        logic ar;
        c = exp_c(p, m);
        ar = m && p >= 8 && p <= 11;
        return {22'h0, g, ar, 1'b1, c != `CRD_DSEL_NONE,
                `CRD_ASEL_STORAGE, 1'b0, c};
    endfunction

    // ==========================================================
    // Stimulus
    initial begin
        rst = 1'b1;
        hsel = 1'b1;
        hsize = 3'h2;
        hwrite = 1'b0;
        htrans = 2'h0;
        haddr = 32'h0;
        hwdata = 32'h0;
        {maint, srd, ts, nr, ns} = 5'h0;
        ac = '{`CRD_ASEL_STORAGE, `CRD_ASEL_MICRO, `CRD_ASEL_CONSOLE,
               `CRD_ASEL_ERROR};
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        bus(32'h0, 1'b0, 32'h0, rd);
        chk(rd, 32'h0);
        bus(32'h4, 1'b0, 32'h0, rd);
        chk(rd, 32'h0);
        // Unmapped place keeps reading zero after a write
        bus(32'h14, 1'b1, 32'hffff_ffff, rd);
        bus(32'h14, 1'b0, 32'h0, rd);
        chk(rd, 32'h0);
        for (int m = 0; m < 2; m++) begin
            for (int g = 0; g < 4; g++) begin
                for (int p = 0; p < 13; p++) begin
                    @(posedge clk);
                    maint <= m[0];
                    nr <= g[0];
                    ns <= g[1];
                    bus(32'h0, 1'b1, 32'(p), rd);
                    bus(32'hc, 1'b0, 32'h0, rd);
                    chk(rd, exp_d(p, m, g == 3));
                    bus(32'h8, 1'b0, 32'h0, rd);
                    chk(rd, exp_s(p, m, g == 3));
                    chk({29'h0, dsel}, {29'h0, exp_c(p, m)});
                    e[1] = m[0] && p > 7 && p < 12;
                    e[0] = e[1] && g == 3;
                    chk({30'h0, aqs, agate}, {30'h0, e[1:0]});
                end
            end
            for (int p = 0; p < 4; p++) begin
                bus(32'h4, 1'b1, 32'(p), rd);
                bus(32'h10, 1'b0, 32'h0, rd);
                e = (!m && p[0]) ? 32'h0 : {16'h0, w[12 + p]};
                chk(rd, e);
                chk({30'h0, asel}, {30'h0, ac[p]});
            end
            bus(32'h4, 1'b1, 32'h0, rd);
        end
        bus(32'h0, 1'b1, 32'h1, rd);
        for (int t = 0; t < 3; t++) begin
            @(posedge clk);
            srd <= (t < 2);
            ts <= (t != 0);
            repeat (2) @(posedge clk);
            e = {16'h0, w[t == 0 ? 11 : t == 1 ? 10 : 0]};
            chk({16'h0, dd}, e);
        end
        srd <= 1'b0;
        stop_test();
    end

    initial begin
        repeat (20000) @(posedge clk);
        fail_count++;
        stop_test();
    end
endmodule // crd_display_select_bench
`default_nettype wire

// ==== sim/crd_src_model.sv ====
// Purpose: Processor-side source words for the display path
// Assumes: One processor stopped, so every word holds still
// Notes: Distinct words make a wrong multiplexer leg visible
`timescale 1ns/1ps
`default_nettype none
`include "crd_params.svh"

// ==========================================================
// Source model
module crd_src_model (
    output var crd_pkg::crd_word_t w_o [16]
);
    import crd_pkg::*;
    // Fixed words; changing ones would make any display check moot
    for (genvar i = 0; i < 16; i++) begin : g_w
        assign w_o[i] = 16'(i * 16'h1111 + 16'h0123);
    end
endmodule // crd_src_model
`default_nettype wire
